//--- core/emulator_break_trace_unit.sv
// break and trace unit of the emulator: watches cpu cycles, stops execution, feeds trace memory
// assumes the cpu, its bus and the ahb-lite master share hclk; the cpu holds off while cpu_stall is high
//
// The AHB-Lite slave port and the address map were left to the implementer.
`timescale 1ns/10ps

// Operation
// - Hardware break halts when a fetch or access matches a selected event.
// - Access breaks are caught at memory stage, so the stop lies past the access.
// - Executing the debug trap instruction planted by the debugger stops the program.
// - Fetch, read or write of an unmapped address stops the program.
// - Any write into the rom area stops the program.
// - Peripheral register access with an illegal width stops the program.
// - Write to read-only or read from write-only peripheral register stops the program.
// - Timer between start and end events reaching its limit stops the program.
// - A forced break request from the debugger always stops the program.
// - During break the cpu runs debug code; interrupts stay pending.
// - Branch trace stores only source and destination of taken branches.
// - Full trace stores the address of every executed instruction.
// - Access trace stores address, data and read or write direction.
// - Cpu general and system register accesses produce no trace entries.
// - Optionally the program counter of the accessing instruction is stored.
// - Lost trace entries, as in long ram bursts, are flagged for the debugger.
// - Priority mode stalls the cpu instead of dropping trace entries.
// - With stamps on, every group of up to four entries carries one time stamp.
// - Dma start and end points are stored as trace entries.
// - Section mode records only between start and end events.
// - Qualify mode stores only cycles matching the qualify events.
// - Delay trigger mode keeps recording for a set delay after the trigger.
// - Two pre-execution address comparators serve only hardware breaks.
// - Six access comparators; a range consumes a pair.
// - Access events match address or range, data, size and direction.
module emulator_break_trace_unit
  import break_trace_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // observed cpu cycles
  input wire fetch_t fetch,
  input wire exec_t exec,
  input wire mem_t mem,
  input wire io_attr_t io_attr,
  input wire logic boundary,
  input wire logic dma_start,
  input wire logic dma_end,
  // cpu control
  output logic cpu_halt,
  output logic cpu_stall,
  output logic irq_hold,
  // trace memory port
  output logic trace_valid,
  output trace_entry_t trace_entry,
  input wire logic trace_ready
);

  typedef struct packed {
    logic hreadyout; logic hresp; logic [31:0] hrdata;
    logic ahb_busy; logic ahb_write; logic [REG_AW-1:0] ahb_addr;
    logic [31:0] ctrl; logic [31:0] evsel; logic [31:0] evsel2;
    logic [PRE_NUM-1:0][31:0] pre_addr;
    logic [31:0] tlimit; logic [31:0] tdelay;
    logic [31:0] rom_lo; logic [31:0] rom_hi; logic [31:0] ram_lo; logic [31:0] ram_hi;
    logic [31:0] io_lo; logic [31:0] io_hi;
    logic [ACC_NUM-1:0][31:0] acc_addr; logic [ACC_NUM-1:0][31:0] acc_data;
    acc_cfg_t [ACC_NUM-1:0] acc_cfg;
    logic [CAUSE_W-1:0] pending; logic [CAUSE_W-1:0] cause; logic [CAUSE_W-1:0] fs_cause;
    logic in_break; logic cpu_halt; logic irq_hold; logic cpu_stall; logic lost;
    logic sec_active; logic trig_armed; logic trig_done; logic [31:0] dcnt;
    logic tmr_run; logic [31:0] tmr_cnt; logic [31:0] ts_cnt; logic [1:0] grp;
    logic tv; trace_entry_t tout;
  } state_t;

  state_t s;
  state_t n;
  logic [31:0] rd_word;
  logic [PRE_NUM-1:0] pre_hit;
  logic [ACC_NUM-1:0] acc_hit;
  logic [EV_NUM-1:0] ev;
  logic [CAUSE_W-1:0] fs;
  logic mem_rom, mem_ram, mem_io, fetch_mapped, mem_live, io_acc, width_ok;
  logic force_req, rec, c_dma, c_acc, c_exe, live, busy, tmr_ovf;
  logic [1:0] ncand;

  function automatic logic in_win(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
    in_win = (a >= lo) && (a <= hi);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // event comparators
  // pre-execution hits look at the fetch address, before the instruction runs
  for (genvar gp = 0; gp < PRE_NUM; gp++) begin : g_pre
    assign pre_hit[gp] = fetch.valid && s.ctrl[CTRL_PRE_EN + gp] && (fetch.pc == s.pre_addr[gp]);
  end

  // access hits come from the memory stage; an even comparator with range set takes its odd partner as limit
  assign mem_live = mem.valid && !mem.sysreg;
  for (genvar gi = 0; gi < ACC_NUM; gi++) begin : g_acc
    localparam int LO = gi - (gi % 2);
    logic range_on, consumed, addr_ok, dir_ok;
    assign range_on = (gi == LO) && s.acc_cfg[LO].range;
    assign consumed = (gi != LO) && s.acc_cfg[LO].range;
    assign addr_ok = range_on ? in_win(mem.addr, s.acc_addr[LO], s.acc_addr[LO + 1]) : (mem.addr == s.acc_addr[gi]);
    assign dir_ok = mem.write ? s.acc_cfg[gi].dir[1] : s.acc_cfg[gi].dir[0];
    assign acc_hit[gi] = mem_live && s.acc_cfg[gi].en && !consumed && addr_ok && dir_ok
      && (!s.acc_cfg[gi].data_match || (mem.data == s.acc_data[gi]))
      && (!s.acc_cfg[gi].size_match || (mem.size == s.acc_cfg[gi].size));
  end
  assign ev = {acc_hit, pre_hit};

  ////////////////////////////////////////////////////////////////////////////
  // fail-safe decode against the programmed memory map
  assign mem_rom = in_win(mem.addr, s.rom_lo, s.rom_hi);
  assign mem_ram = in_win(mem.addr, s.ram_lo, s.ram_hi);
  assign mem_io = in_win(mem.addr, s.io_lo, s.io_hi);
  assign fetch_mapped = in_win(fetch.pc, s.rom_lo, s.rom_hi) || in_win(fetch.pc, s.ram_lo, s.ram_hi)
    || in_win(fetch.pc, s.io_lo, s.io_hi);
  assign io_acc = mem_live && mem_io;
  assign width_ok = ((mem.size == SZ_BYTE) && io_attr.widths[0]) || ((mem.size == SZ_HALF) && io_attr.widths[1])
    || ((mem.size == SZ_WORD) && io_attr.widths[2]);
  assign fs[FS_NONMAP] = s.ctrl[CTRL_FS_EN] && ((mem_live && !(mem_rom || mem_ram || mem_io))
    || (fetch.valid && !fetch_mapped));
  assign fs[FS_ROMWR] = s.ctrl[CTRL_FS_EN] && mem_live && mem.write && mem_rom;
  assign fs[FS_WIDTH] = s.ctrl[CTRL_FS_EN] && io_acc && !width_ok;
  assign fs[FS_RO_WR] = s.ctrl[CTRL_FS_EN] && io_acc && mem.write && !io_attr.writable;
  assign fs[FS_WO_RD] = s.ctrl[CTRL_FS_EN] && io_acc && !mem.write && !io_attr.readable;

  ////////////////////////////////////////////////////////////////////////////
  // register read mux, used in the first data-phase cycle and registered into hrdata
  always_comb begin
    rd_word = 32'h0;
    case (s.ahb_addr[REG_AW-1:REGION_LSB])
      REGION_ACC_ADDR: if (s.ahb_addr[IDX_LSB +: IDX_W] < ACC_NUM) rd_word = s.acc_addr[s.ahb_addr[IDX_LSB +: IDX_W]];
      REGION_ACC_DATA: if (s.ahb_addr[IDX_LSB +: IDX_W] < ACC_NUM) rd_word = s.acc_data[s.ahb_addr[IDX_LSB +: IDX_W]];
      REGION_ACC_CFG: if (s.ahb_addr[IDX_LSB +: IDX_W] < ACC_NUM) rd_word = 32'(s.acc_cfg[s.ahb_addr[IDX_LSB +: IDX_W]]);
      default: begin
        case (s.ahb_addr)
          OFS_CTRL: rd_word = s.ctrl;
          OFS_STATUS: rd_word = {17'h0, s.tmr_run, s.trig_done, s.sec_active, s.lost, s.fs_cause, s.cause, s.in_break};
          OFS_EVSEL: rd_word = s.evsel;
          OFS_EVSEL2: rd_word = s.evsel2;
          OFS_PRE0: rd_word = s.pre_addr[0];
          OFS_PRE1: rd_word = s.pre_addr[1];
          OFS_TLIMIT: rd_word = s.tlimit;
          OFS_TDELAY: rd_word = s.tdelay;
          OFS_ROM_LO: rd_word = s.rom_lo;
          OFS_ROM_HI: rd_word = s.rom_hi;
          OFS_RAM_LO: rd_word = s.ram_lo;
          OFS_RAM_HI: rd_word = s.ram_hi;
          OFS_IO_LO: rd_word = s.io_lo;
          OFS_IO_HI: rd_word = s.io_hi;
          OFS_TSTAMP: rd_word = s.ts_cnt;
          default: rd_word = 32'h0; // unmapped reads as zero, still okay
        endcase
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    logic [CAUSE_W-1:0] src;
    logic [IDX_W-1:0] idx;
    trace_entry_t e;
    force_req = 1'b0;
    rec = 1'b0;
    src = '0;
    e = '0;
    idx = s.ahb_addr[IDX_LSB +: IDX_W];
    n = s;
    n.hresp = 1'b0;
    // one wait state per transfer: hrdata must come from a flop
    if (s.ahb_busy) begin
      n.ahb_busy = 1'b0;
      n.hreadyout = 1'b1;
      if (!s.ahb_write) begin
        n.hrdata = rd_word;
      end else if (s.ahb_addr[REG_AW-1:REGION_LSB] == REGION_ACC_ADDR) begin
        if (idx < ACC_NUM) n.acc_addr[idx] = hwdata;
      end else if (s.ahb_addr[REG_AW-1:REGION_LSB] == REGION_ACC_DATA) begin
        if (idx < ACC_NUM) n.acc_data[idx] = hwdata;
      end else if (s.ahb_addr[REG_AW-1:REGION_LSB] == REGION_ACC_CFG) begin
        if (idx < ACC_NUM) n.acc_cfg[idx] = acc_cfg_t'(hwdata[$bits(acc_cfg_t)-1:0]);
      end else begin
        case (s.ahb_addr)
          OFS_CTRL: begin
            n.ctrl = hwdata & CTRL_WMASK;
            force_req = hwdata[CTRL_FORCE];
            if (hwdata[CTRL_RESUME]) begin
              n.in_break = 1'b0;
              n.cpu_halt = 1'b0;
              n.irq_hold = 1'b0; // held interrupts may now be taken
              n.fs_cause = '0;
            end
          end
          OFS_STATUS: if (hwdata[STATUS_LOST]) n.lost = 1'b0;
          OFS_EVSEL: n.evsel = hwdata;
          OFS_EVSEL2: n.evsel2 = hwdata;
          OFS_PRE0: n.pre_addr[0] = hwdata;
          OFS_PRE1: n.pre_addr[1] = hwdata;
          OFS_TLIMIT: n.tlimit = hwdata;
          OFS_TDELAY: n.tdelay = hwdata;
          OFS_ROM_LO: n.rom_lo = hwdata;
          OFS_ROM_HI: n.rom_hi = hwdata;
          OFS_RAM_LO: n.ram_lo = hwdata;
          OFS_RAM_HI: n.ram_hi = hwdata;
          OFS_IO_LO: n.io_lo = hwdata;
          OFS_IO_HI: n.io_hi = hwdata;
          default: n.ahb_write = 1'b0; // unmapped or read-only: write ignored
        endcase
      end
    end else if (hsel && htrans[1] && hready) begin
      n.ahb_busy = 1'b1;
      n.hreadyout = 1'b0;
      n.ahb_write = hwrite;
      n.ahb_addr = haddr[REG_AW-1:0];
    end

    // measurement timer between start and end events
    tmr_ovf = s.tmr_run && (s.tmr_cnt >= s.tlimit);
    if (s.tmr_run) n.tmr_cnt = s.tmr_cnt + 32'h1;
    if (!s.tmr_run && |(ev & ACC_EV_MASK & s.evsel2[EVS2_TMR_START +: EV_NUM])) begin
      n.tmr_run = 1'b1;
      n.tmr_cnt = 32'h0;
    end else if (tmr_ovf || |(ev & ACC_EV_MASK & s.evsel2[EVS2_TMR_END +: EV_NUM])) begin
      n.tmr_run = 1'b0;
    end

    // break sources collect while the program runs; the halt waits for an instruction boundary
    if (!s.in_break) begin
      src[CAUSE_HW] = |(ev & s.evsel[EVS_BRK +: EV_NUM]);
      src[CAUSE_SW] = exec.valid && exec.trap;
      src[CAUSE_FS] = |fs;
      src[CAUSE_TMR] = tmr_ovf && s.ctrl[CTRL_TMR_EN];
      src[CAUSE_FORCE] = force_req;
      n.pending = s.pending | src;
      n.fs_cause = s.fs_cause | fs;
      if (boundary && (n.pending != '0)) begin
        n.in_break = 1'b1;
        n.cpu_halt = 1'b1;
        n.irq_hold = 1'b1;
        n.cause = n.pending;
        n.pending = '0;
      end
    end

    // trace recording window per mode
    case (s.ctrl[CTRL_MODE_LSB +: 3])
      TMODE_FREE: rec = 1'b1;
      TMODE_SECTION: rec = s.sec_active || |(ev & ACC_EV_MASK & s.evsel[EVS_SEC_START +: EV_NUM]);
      TMODE_QUALIFY: rec = |(ev & ACC_EV_MASK & s.evsel[EVS_QUAL +: EV_NUM]);
      TMODE_DELAY: rec = !s.trig_done;
      default: rec = 1'b0;
    endcase
    if (s.ctrl[CTRL_TRACE_EN]) begin
      n.ts_cnt = s.ts_cnt + 32'h1;
      if (|(ev & ACC_EV_MASK & s.evsel[EVS_SEC_START +: EV_NUM])) n.sec_active = 1'b1;
      if (|(ev & ACC_EV_MASK & s.evsel[EVS_SEC_END +: EV_NUM])) n.sec_active = 1'b0;
      if (s.trig_armed) begin
        if (s.dcnt == 32'h0) begin
          n.trig_armed = 1'b0;
          n.trig_done = 1'b1;
        end else begin
          n.dcnt = s.dcnt - 32'h1;
        end
      end else if (!s.trig_done && |(ev & ACC_EV_MASK & s.evsel2[EVS2_TRIG +: EV_NUM])) begin
        n.trig_armed = 1'b1;
        n.dcnt = s.tdelay;
      end
    end else begin
      // stamps count from trace start, so disabling restarts stamps, group, section and trigger
      n.ts_cnt = 32'h0;
      n.grp = 2'h0;
      n.sec_active = 1'b0;
      n.trig_armed = 1'b0;
      n.trig_done = 1'b0;
    end

    // candidates for this cycle, one entry slot; dma cannot be stalled so it goes first
    live = s.ctrl[CTRL_TRACE_EN] && rec && !s.in_break;
    c_dma = live && (dma_start || dma_end);
    c_acc = live && mem_live && s.ctrl[CTRL_ACC];
    c_exe = live && exec.valid && (s.ctrl[CTRL_FULL] || exec.branch);
    ncand = {1'b0, c_dma} + {1'b0, c_acc} + {1'b0, c_exe};
    busy = s.tv && !trace_ready;
    if (s.tv && trace_ready) n.tv = 1'b0;
    if (c_dma) begin
      e.kind = dma_start ? KIND_DMA_START : KIND_DMA_END;
    end else if (c_acc) begin
      e.kind = KIND_ACCESS;
      e.rw = mem.write;
      e.addr = mem.addr;
      e.data = mem.data;
      e.pc = s.ctrl[CTRL_ACC_PC] ? mem.pc : 32'h0;
    end else if (s.ctrl[CTRL_FULL]) begin
      e.kind = KIND_EXEC;
      e.addr = exec.pc;
    end else begin
      e.kind = KIND_BRANCH;
      e.addr = exec.pc;
      e.data = exec.target;
    end
    e.ts_valid = s.ctrl[CTRL_TSTAMP] && (s.grp == 2'h0);
    e.ts = e.ts_valid ? s.ts_cnt : 32'h0;
    if ((ncand != 2'h0) && !busy) begin
      n.tv = 1'b1;
      n.tout = e;
      n.grp = s.grp + 2'h1;
    end
    // a second candidate in one cycle, or any while the slot is blocked, is lost; set beats clear
    if ((ncand > 2'h1) || ((ncand != 2'h0) && busy)) n.lost = 1'b1;
    // priority mode holds the cpu while the slot is full, trading real time for completeness
    n.cpu_stall = s.ctrl[CTRL_PRIO] && n.tv;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.hreadyout <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign hreadyout = s.hreadyout;
  assign hresp = s.hresp;
  assign hrdata = s.hrdata;
  assign cpu_halt = s.cpu_halt;
  assign cpu_stall = s.cpu_stall;
  assign irq_hold = s.irq_hold;
  assign trace_valid = s.tv;
  assign trace_entry = s.tout;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_hw_break;
    !s.in_break && |(ev & s.evsel[EVS_BRK +: EV_NUM]) |=> s.pending[CAUSE_HW] || s.cause[CAUSE_HW];
  endproperty
  a_hw_break: assert property (p_hw_break) else $error("event hit did not raise hardware break");

  property p_trap;
    !s.in_break && exec.valid && exec.trap |=> s.pending[CAUSE_SW] || s.cause[CAUSE_SW];
  endproperty
  a_trap: assert property (p_trap) else $error("trap instruction did not raise break");

  property p_nonmap;
    !s.in_break && s.ctrl[CTRL_FS_EN] && fetch.valid && !fetch_mapped |=> s.fs_cause[FS_NONMAP];
  endproperty
  a_nonmap: assert property (p_nonmap) else $error("unmapped fetch not flagged");

  property p_romwr;
    !s.in_break && s.ctrl[CTRL_FS_EN] && mem_live && mem.write && mem_rom |=> s.fs_cause[FS_ROMWR];
  endproperty
  a_romwr: assert property (p_romwr) else $error("rom write not flagged");

  property p_timer;
    !s.in_break && s.ctrl[CTRL_TMR_EN] && s.tmr_run && (s.tmr_cnt >= s.tlimit)
      |=> s.pending[CAUSE_TMR] || s.cause[CAUSE_TMR];
  endproperty
  a_timer: assert property (p_timer) else $error("timer overflow did not raise break");

  property p_halt_cause;
    $rose(s.cpu_halt) |-> $past(boundary) && (s.cause != '0) && s.in_break;
  endproperty
  a_halt_cause: assert property (p_halt_cause) else $error("halt without boundary or cause");

  property p_irq_hold;
    s.cpu_halt |-> s.irq_hold ##1 (s.irq_hold || !s.in_break);
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupts released during break");

  property p_stall;
    s.ctrl[CTRL_PRIO] && s.tv && !trace_ready |=> s.cpu_stall && s.tv;
  endproperty
  a_stall: assert property (p_stall) else $error("priority mode did not stall cpu");

  property p_lost;
    s.ctrl[CTRL_TRACE_EN] && (s.ctrl[CTRL_MODE_LSB +: 3] == TMODE_FREE) && !s.in_break
      && s.tv && !trace_ready && (dma_start || dma_end) |=> s.lost;
  endproperty
  a_lost: assert property (p_lost) else $error("dropped trace entry not flagged");

  c_halt: cover property ($rose(s.cpu_halt));
  c_force: cover property (s.ahb_busy && s.ahb_write && (s.ahb_addr == OFS_CTRL) && hwdata[CTRL_FORCE]);
  c_stall: cover property (s.cpu_stall && s.tv ##1 !s.tv);
  c_lost: cover property ($rose(s.lost));

endmodule

//--- core/break_trace_pkg.sv
// constants, register map and carrier types of the emulator break and trace unit
// assumes one clock domain shared with the observed cpu and the ahb-lite bus
package break_trace_pkg;

  // comparator counts and event vector layout
  localparam int PRE_NUM = 2;
  localparam int ACC_NUM = 6;
  localparam int EV_NUM = PRE_NUM + ACC_NUM;
  localparam logic [EV_NUM-1:0] ACC_EV_MASK = 8'hfc; // pre-execution bits may only break

  ////////////////////////////////////////////////////////////////////////////
  // register map, byte offsets within the slave window
  localparam int REG_AW = 8;
  localparam logic [REG_AW-1:0] OFS_CTRL = 8'h00;
  localparam logic [REG_AW-1:0] OFS_STATUS = 8'h04;
  localparam logic [REG_AW-1:0] OFS_EVSEL = 8'h08;
  localparam logic [REG_AW-1:0] OFS_EVSEL2 = 8'h0c;
  localparam logic [REG_AW-1:0] OFS_PRE0 = 8'h10;
  localparam logic [REG_AW-1:0] OFS_PRE1 = 8'h14;
  localparam logic [REG_AW-1:0] OFS_TLIMIT = 8'h18;
  localparam logic [REG_AW-1:0] OFS_TDELAY = 8'h1c;
  localparam logic [REG_AW-1:0] OFS_ROM_LO = 8'h20;
  localparam logic [REG_AW-1:0] OFS_ROM_HI = 8'h24;
  localparam logic [REG_AW-1:0] OFS_RAM_LO = 8'h28;
  localparam logic [REG_AW-1:0] OFS_RAM_HI = 8'h2c;
  localparam logic [REG_AW-1:0] OFS_IO_LO = 8'h30;
  localparam logic [REG_AW-1:0] OFS_IO_HI = 8'h34;
  localparam logic [REG_AW-1:0] OFS_TSTAMP = 8'h38;
  // comparator banks: 32-byte regions selected by address bits 7:5, word index in 4:2
  localparam int REGION_LSB = 5;
  localparam int IDX_LSB = 2;
  localparam int IDX_W = 3;
  localparam logic [2:0] REGION_ACC_ADDR = 3'h2;
  localparam logic [2:0] REGION_ACC_DATA = 3'h3;
  localparam logic [2:0] REGION_ACC_CFG = 3'h4;

  // control register bits
  localparam int CTRL_TRACE_EN = 0;
  localparam int CTRL_MODE_LSB = 1; // three bits
  localparam int CTRL_FULL = 4;
  localparam int CTRL_ACC = 5;
  localparam int CTRL_ACC_PC = 6;
  localparam int CTRL_TSTAMP = 7;
  localparam int CTRL_PRIO = 8;
  localparam int CTRL_PRE_EN = 9; // two bits
  localparam int CTRL_FS_EN = 11;
  localparam int CTRL_TMR_EN = 12;
  localparam int CTRL_FORCE = 16;
  localparam int CTRL_RESUME = 17;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_1fff;
  localparam int STATUS_LOST = 11;

  // event select fields
  localparam int EVS_BRK = 0;
  localparam int EVS_SEC_START = 8;
  localparam int EVS_SEC_END = 16;
  localparam int EVS_QUAL = 24;
  localparam int EVS2_TRIG = 0;
  localparam int EVS2_TMR_START = 8;
  localparam int EVS2_TMR_END = 16;

  // trace modes
  localparam logic [2:0] TMODE_OFF = 3'h0;
  localparam logic [2:0] TMODE_FREE = 3'h1;
  localparam logic [2:0] TMODE_SECTION = 3'h2;
  localparam logic [2:0] TMODE_QUALIFY = 3'h3;
  localparam logic [2:0] TMODE_DELAY = 3'h4;

  // break causes and fail-safe reasons
  localparam int CAUSE_W = 5;
  localparam int CAUSE_HW = 0;
  localparam int CAUSE_SW = 1;
  localparam int CAUSE_FS = 2;
  localparam int CAUSE_TMR = 3;
  localparam int CAUSE_FORCE = 4;
  localparam int FS_NONMAP = 0;
  localparam int FS_ROMWR = 1;
  localparam int FS_WIDTH = 2;
  localparam int FS_RO_WR = 3;
  localparam int FS_WO_RD = 4;

  // access sizes and trace entry kinds
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  localparam logic [2:0] KIND_BRANCH = 3'h1;
  localparam logic [2:0] KIND_EXEC = 3'h2;
  localparam logic [2:0] KIND_ACCESS = 3'h3;
  localparam logic [2:0] KIND_DMA_START = 3'h4;
  localparam logic [2:0] KIND_DMA_END = 3'h5;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {logic valid; logic [31:0] pc;} fetch_t;
  typedef struct packed {logic valid; logic [31:0] pc; logic trap; logic branch; logic [31:0] target;} exec_t;
  typedef struct packed {
    logic valid; logic [31:0] addr; logic [31:0] data; logic write; logic [1:0] size;
    logic [31:0] pc; logic sysreg;
  } mem_t;
  typedef struct packed {logic [2:0] widths; logic readable; logic writable;} io_attr_t;
  typedef struct packed {
    logic en; logic range; logic data_match; logic size_match; logic [1:0] dir; logic [1:0] size;
  } acc_cfg_t;
  typedef struct packed {
    logic [2:0] kind; logic rw; logic [31:0] addr; logic [31:0] data; logic [31:0] pc;
    logic ts_valid; logic [31:0] ts;
  } trace_entry_t;

endpackage

//--- tb/cpu_model.sv
// cpu model: one-cycle fetch, exec and memory cycles
// assumes hclk is shared with the unit
`timescale 1ns/10ps
module cpu_model
  import break_trace_pkg::*;
(
  // clock and control
  input wire logic hclk,
  input wire logic cpu_stall,
  // cycles
  output fetch_t fetch,
  output exec_t exec,
  output mem_t mem,
  // high once a stall outlasts its bound
  output logic stuck
);
  initial begin
    fetch = '0;
    exec = '0;
    mem = '0;
    stuck = 1'b0;
  end
  // t plants the debug trap, else a memory access
  task automatic issue(input logic t, input logic [31:0] a, d, input logic w, s);
    int n = 0;
    while (cpu_stall === 1'b1 && n < 64) begin
      @(posedge hclk);
      n++;
    end
    stuck <= (n == 64);
    fetch <= '{1'b1, a};
    exec <= '{1'b1, a, t, 1'b0, 32'h0};
    mem <= '{~t, a, d, w, SZ_WORD, a, s};
    @(posedge hclk);
    fetch <= '0;
    exec <= '0;
    mem <= '0;
  endtask
endmodule

//--- tb/emulator_break_trace_unit_tb_top.sv
// bench: registers, breaks and access trace against a queue model
// assumes the cpu model; trace memory ready except in the blocked-slot test
`timescale 1ns/10ps
module emulator_break_trace_unit_tb_top
  import break_trace_pkg::*;
;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd, v;
  logic hreadyout, hresp, cpu_halt, cpu_stall, irq_hold, trace_valid, stuck;
  logic tr_rdy = 1'b1, bnd = 1'b1, dma_s = 1'b0, dma_e = 1'b0;
  logic [4:0] ioa = 5'h1f;
  trace_entry_t trace_entry;
  fetch_t fetch;
  exec_t exec;
  mem_t mem;
  trace_entry_t q[$];
  int n_mismatch = 0;
  int tests_run = 0;
  int seed = 94;
  always #2.5 hclk = ~hclk;
  emulator_break_trace_unit u_emulator_break_trace_unit (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .fetch, .exec, .mem, .io_attr(ioa),
    .boundary(bnd), .dma_start(dma_s), .dma_end(dma_e), .cpu_halt, .cpu_stall, .irq_hold, .trace_valid,
    .trace_entry, .trace_ready(tr_rdy));
  cpu_model u_cpu_model (.hclk, .cpu_stall, .fetch, .exec, .mem, .stuck);
  // a cpu model stalled past its bound ends the run
  always @(posedge hclk) if (stuck === 1'b1) begin
    n_mismatch++;
    end_sim;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("tests_run=%0d n_mismatch=%0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // hready is looked at before the edge, so no race with the slave's update
  task automatic wt;
    int n;
    logic ok;
    n = 0;
    do begin
      @(negedge hclk);
      ok = hreadyout;
      rd = hrdata;
      @(posedge hclk);
      n++;
    end while (ok !== 1'b1 && n < 40);
    if (ok !== 1'b1) begin
      n_mismatch++;
      end_sim;
    end
  endtask
  // hsel stays up between transfers so it is never driven twice in a step
  task automatic ahb(input logic w, input logic [31:0] a, d);
    hwrite <= w;
    haddr <= a;
    htrans <= 2'h2;
    hsel <= 1'b1;
    wt;
    htrans <= 2'h0;
    hwdata <= d;
    wt;
  endtask
  // a break holds cpu and interrupts and reports its cause until resume
  task automatic brk(input logic [31:0] c, st);
    repeat (3) @(posedge hclk);
    chk({cpu_halt, irq_hold}, 2'h3);
    ahb(0, OFS_STATUS, 0);
    chk(rd, st);
    ahb(1, OFS_CTRL, c | 32'h0002_0000);
    @(posedge hclk);
    chk(cpu_halt, 1'b0);
    $display("break test done");
  endtask
  // trace model: each entry must be the next queued one
  always @(negedge hclk) begin
    if (trace_valid !== 1'b0 && tr_rdy) begin
      if (q.size() == 0) chk(trace_valid, 1'b0);
      else begin
        chk({trace_entry.kind, trace_entry.rw}, {q[0].kind, q[0].rw});
        chk(trace_entry.addr ^ trace_entry.data ^ trace_entry.pc, q[0].addr ^ q[0].data);
        void'(q.pop_front());
      end
    end
  end
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    v = $random(seed);
    ahb(0, OFS_CTRL, 0);
    chk(rd, 32'h0);
    ahb(1, 32'h0000_00a0, v);
    ahb(0, 32'h0000_00a0, 0);
    chk(rd, 32'h0);
    ahb(1, OFS_CTRL, 32'h0000_0023);
    ahb(0, OFS_CTRL, 0);
    chk(rd, 32'h0000_0023);
    q.push_back('{kind: KIND_ACCESS, rw: 1'b1, addr: 32'h100, data: v, default: '0});
    u_cpu_model.issue(0, 32'h100, v, 1, 0);
    u_cpu_model.issue(0, 32'h104, v, 0, 1);
    q.push_back('{kind: KIND_DMA_START, default: '0});
    q.push_back('{kind: KIND_DMA_END, default: '0});
    dma_s <= 1'b1;
    @(posedge hclk);
    dma_s <= 1'b0;
    dma_e <= 1'b1;
    @(posedge hclk);
    dma_e <= 1'b0;
    repeat (3) @(posedge hclk);
    chk(q.size(), 0);
    // slot blocked: the second access is dropped and flagged
    tr_rdy <= 1'b0;
    q.push_back('{kind: KIND_ACCESS, rw: 1'b0, addr: 32'h108, data: v, default: '0});
    u_cpu_model.issue(0, 32'h108, v, 0, 0);
    u_cpu_model.issue(0, 32'h10c, v, 0, 0);
    ahb(0, OFS_STATUS, 0);
    chk(rd, 32'h1 << STATUS_LOST);
    ahb(1, OFS_CTRL, 32'h0000_0123);
    @(posedge hclk);
    chk(cpu_stall, 1'b1);
    tr_rdy <= 1'b1;
    repeat (2) @(posedge hclk);
    chk(cpu_stall, 1'b0);
    chk(q.size(), 0);
    ahb(1, OFS_STATUS, 32'h1 << STATUS_LOST);
    $display("trace test done");
    ahb(1, OFS_CTRL, 0);
    u_cpu_model.issue(1, 32'h200, 0, 0, 0);
    brk(0, 32'h1 | 32'h1 << (1 + CAUSE_SW));
    bnd <= 1'b0;
    ahb(1, OFS_CTRL, 32'h0001_0000);
    repeat (2) @(posedge hclk);
    chk(cpu_halt, 1'b0);
    bnd <= 1'b1;
    brk(0, 32'h1 | 32'h1 << (1 + CAUSE_FORCE));
    ahb(1, OFS_ROM_HI, 32'h0000_0fff);
    ahb(1, OFS_CTRL, 32'h0000_0800);
    u_cpu_model.issue(0, 32'h10, v, 1, 0);
    brk(32'h800, 32'h9 | 32'h1 << (6 + FS_ROMWR));
    u_cpu_model.issue(0, 32'h5000, v, 0, 0);
    brk(32'h800, 32'h9 | 32'h1 << (6 + FS_NONMAP));
    ahb(1, 32'h0000_0040, 32'h0000_0100);
    ahb(1, 32'h0000_0080, 32'h0000_008c);
    ahb(1, OFS_EVSEL, 32'h0000_0004);
    u_cpu_model.issue(0, 32'h100, v, 0, 0);
    brk(32'h800, 32'h1 | 32'h1 << (1 + CAUSE_HW));
    ahb(1, OFS_IO_LO, 32'h0000_3000);
    ahb(1, OFS_IO_HI, 32'h0000_3fff);
    ioa <= 5'h05;
    u_cpu_model.issue(0, 32'h3000, v, 0, 0);
    brk(32'h800, 32'h9 | 32'h1 << (6 + FS_WIDTH) | 32'h1 << (6 + FS_WO_RD));
    end_sim;
  end
endmodule
